// *** spi_client.sv ***
// spi client with multi-host fallback and buffered modes
// assumes: avalon-mm master on sys_clk, serial pins asynchronous
// assumes: remote host holds each sck phase over two clocks
// assumes: miso pad enable is low active, pad outside
// assumes: software polls flags, no interrupt line
// assumes: sys_clk far faster than sck
// Contract
// - low select drops host to client, flags
// - select-ignore set: select pin unused in host mode
// - select as output never affects host
// - client stays until software sets host
// - unbuffered client idle while select high
// - shift from first clock, flag byte
// - busy unbuffered write dropped, collision flag
// - select high resets counter, drops byte
// - buffered enable adds buffers and flags
// - wait-for-receive 0: dummy byte first
// - write to full buffer is dropped
// - empty flag falls on write, rises on move
// - receive flag one cycle after empty
// - transfer flag next cycle, all sent
// - wait-for-receive 1: first write to shifter
// - both buffered variants share flag behaviour
// - select, mosi, sck are inputs only
// - miso driven only while selected
// - four modes, opposite shift/sample edges
`timescale 1ns/10ps
`default_nettype none
module spi_client
    import spi_client_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // avalon-mm slave
    input  wire avl_req_type avl_req,
    output logic [31:0]      avl_readdata,
    output logic             avl_waitrequest,
    // serial pins
    input  wire spi_in_type  spi_in,
    output logic             miso_out,
    output logic             miso_oe_n
);
    ////////////////////////////////////////////////////////////
    // whole state of the block
    // every field is a flop; reset and next state stay in step
    typedef struct packed {
        logic [1:0]  sck_sy;     // sck synchroniser
        logic [1:0]  ss_sy;      // select synchroniser
        logic [1:0]  mosi_sy;    // mosi synchroniser
        logic        sck_d;      // sck one cycle late
        logic [7:0]  ctrl_a;     // control_reg_a
        logic [7:0]  ctrl_b;     // control_reg_b
        logic        f_if;       // byte done / host lost
        logic        f_write_collision_flag;    // write_collision_flag
        logic        f_rxc;      // receive_complete_flag
        logic        f_txc;      // transfer_complete_flag
        logic        f_dre;      // tx_buffer_empty_flag
        logic [7:0]  sh;         // shift register
        logic [7:0]  rx;         // received byte
        logic [7:0]  txb;        // transmit holding buffer
        logic        txb_full;   // holding buffer occupied
        logic        sh_loaded;  // shifter holds fresh data
        logic [2:0]  cnt;        // bits sampled
        logic        pend;       // sampled bit waits shift
        logic        rxbit;      // sampled bit
        logic        done_d1;    // byte done, delayed 1
        logic        done_d2;    // byte done, delayed 2
        logic        waitreq;    // avalon waitrequest
        logic [31:0] rdata;      // avalon readdata
        logic        miso;       // miso level
        logic        miso_oe_n;  // miso enable, low drives
    } st_type;

    // one copy in flops, one computed each cycle
    st_type st_r;   // registered state
    st_type st_nxt; // next state

    ////////////////////////////////////////////////////////////
    // shift one bit in, order picked by lsb-first
    // shared by the shift edge and the byte completion,
    // so both paths keep one bit order
    function automatic logic [7:0] shift_in(
        input logic [7:0] v,
        input logic       b,
        input logic       lsb
    );
        shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction

    ////////////////////////////////////////////////////////////
    // decoded controls and pin levels
    // plain wires from the state and the bus request, nothing stored
    logic       enable;    // unit enabled
    logic       host;      // host mode selected
    logic       lsb;       // lsb first
    logic       cpol;      // idle clock level
    logic       cpha;      // sample on trailing edge
    logic       select_ignore_bit;       // select_ignore_bit
    logic       ss_out;    // select pin is an output
    logic       buffered;  // buffered_mode_enable
    logic       wfr;       // wait_for_receive_bit
    logic       client;    // active as client
    logic       ss_high;   // synchronised select level
    logic       sck;       // synchronised sck level
    logic       lead;      // leading sck edge
    logic       trail;     // trailing sck edge
    logic       samp;      // sample edge
    logic       shft;      // shift edge
    logic       accept;    // bus request taken
    logic       wr_do;     // bus write takes effect
    logic [2:0] idx;       // register index
    logic       mapped;    // aligned address
    logic [7:0] byte_in;   // byte at completion
    logic [7:0] rd_byte;   // read data mux

    // control fields
    // client means enabled with the host bit clear
    assign enable   = st_r.ctrl_a[CA_ENABLE];
    assign host     = st_r.ctrl_a[CA_HOST];
    assign lsb      = st_r.ctrl_a[CA_LSB];
    assign cpol     = st_r.ctrl_b[CB_CPOL];
    assign cpha     = st_r.ctrl_b[CB_CPHA];
    assign select_ignore_bit      = st_r.ctrl_b[CB_SSD];
    assign ss_out   = st_r.ctrl_b[CB_SS_OUT];
    assign buffered = st_r.ctrl_b[CB_BUF];
    assign wfr      = st_r.ctrl_b[CB_WFR];
    assign client   = enable && !host;
    // two flops per pin against metastability;
    // a pin change shows up two cycles later
    // only second synchroniser stages are read here
    assign ss_high  = st_r.ss_sy[1];
    assign sck      = st_r.sck_sy[1];
    // an edge is a change against the copy one cycle older;
    // lead leaves the idle level, trail returns to it
    // edge mapping
    assign lead     = (sck != st_r.sck_d) && (sck != cpol);
    assign trail    = (sck != st_r.sck_d) && (sck == cpol);
    // cpha picks the sampling edge, the other one shifts
    // opposite edges
    assign samp     = cpha ? trail : lead;
    assign shft     = cpha ? lead : trail;
    // bus decode
    // taken while waitrequest is high; a write acts only in
    // the answer cycle, so it lands exactly once
    assign idx      = avl_req.address[ADDR_W-1:2];
    assign mapped   = (avl_req.address[1:0] == 2'h0);
    assign accept   = (avl_req.read || avl_req.write) && st_r.waitreq;
    assign wr_do    = avl_req.write && !st_r.waitreq && mapped
                      && avl_req.byteenable[0];
    assign byte_in  = shift_in(st_r.sh, st_r.mosi_sy[1], lsb);

    ////////////////////////////////////////////////////////////
    // read data selection
    // reads have no side effects; flags clear by writing one
    always_comb begin
        rd_byte = 8'h00;
        if (mapped) begin
            case (idx)
                IDX_CTRL_A: rd_byte = st_r.ctrl_a;
                IDX_CTRL_B: rd_byte = st_r.ctrl_b;
                // two layouts share one address
                // flag layout follows buffered mode
                IDX_FLAGS: begin
                    if (buffered) begin
                        rd_byte[FL_RXC] = st_r.f_rxc;
                        rd_byte[FL_TXC] = st_r.f_txc;
                        rd_byte[FL_DRE] = st_r.f_dre;
                    end else begin
                        rd_byte[FL_IF]    = st_r.f_if;
                        rd_byte[FL_WRITE_COLLISION_FLAG] = st_r.f_write_collision_flag;
                    end
                end
                IDX_DATA: rd_byte = st_r.rx;
                // unmapped words read zero
                default: rd_byte = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // next state
    // later assignments win: hardware sets sit after the
    // software clears, so a set beats a clear in one cycle
    always_comb begin
        st_nxt = st_r;
        // pins enter the synchronisers every cycle
        // pins sampled as inputs only
        st_nxt.sck_sy  = {st_r.sck_sy[0], spi_in.sck};
        st_nxt.ss_sy   = {st_r.ss_sy[0], spi_in.ss_n};
        st_nxt.mosi_sy = {st_r.mosi_sy[0], spi_in.mosi};
        st_nxt.sck_d   = sck;
        st_nxt.done_d1 = 1'b0;
        st_nxt.done_d2 = st_r.done_d1;

        // bus handshake: one wait cycle, then answer
        // readdata is caught at take time and held until the
        // next request, so a slow master still finds it
        st_nxt.waitreq = !accept;
        if (accept) begin
            st_nxt.rdata = {24'h0, rd_byte};
        end

        // control writes
        // reserved bits masked, they always read zero
        if (wr_do && idx == IDX_CTRL_A) begin
            st_nxt.ctrl_a = avl_req.writedata[7:0] & CA_MASK;
        end
        if (wr_do && idx == IDX_CTRL_B) begin
            st_nxt.ctrl_b = avl_req.writedata[7:0] & CB_MASK;
        end

        // flag clears, write one to clear
        // only the two upper bits of the layout clear;
        // the empty flag follows the buffer, read only
        if (wr_do && idx == IDX_FLAGS) begin
            if (buffered) begin
                if (avl_req.writedata[FL_RXC]) begin
                    st_nxt.f_rxc = 1'b0;
                end
                if (avl_req.writedata[FL_TXC]) begin
                    st_nxt.f_txc = 1'b0;
                end
            end else begin
                if (avl_req.writedata[FL_IF]) begin
                    st_nxt.f_if = 1'b0;
                end
                if (avl_req.writedata[FL_WRITE_COLLISION_FLAG]) begin
                    st_nxt.f_write_collision_flag = 1'b0;
                end
            end
        end

        // data register writes
        // unbuffered: straight to the shifter unless a byte
        // is under way; buffered: holding buffer only
        if (wr_do && idx == IDX_DATA) begin
            if (buffered) begin
                // writes go to holding buffer only while it is empty
                if (st_r.f_dre) begin
                    st_nxt.txb      = avl_req.writedata[7:0];
                    st_nxt.txb_full = 1'b1;
                    st_nxt.f_dre    = 1'b0;
                end
            end else if (client && !ss_high
                         && (st_r.cnt != 3'h0 || st_r.pend)) begin
                st_nxt.f_write_collision_flag = 1'b1;
            end else begin
                st_nxt.sh        = avl_req.writedata[7:0];
                st_nxt.sh_loaded = 1'b1;
            end
        end

        // the copy trails the write by one cycle and happens
        // only while deselected, never inside a frame
        // first write moves to shifter
        if (client && buffered && wfr && ss_high
            && st_r.txb_full && !st_r.sh_loaded) begin
            st_nxt.sh        = st_r.txb;
            st_nxt.sh_loaded = 1'b1;
            st_nxt.txb_full  = 1'b0;
            st_nxt.f_dre     = 1'b1;
        end

        // host fallback on a low select input
        // another host pulling select low wins; software sets
        // the host bit again, a same-cycle write loses
        // select ignored when ssd set
        if (enable && host && !select_ignore_bit && !ss_out && !ss_high) begin
            st_nxt.ctrl_a[CA_HOST] = 1'b0;
            st_nxt.f_if            = 1'b1;
        end

        // shift engine
        // a sample edge takes and counts the mosi bit; the
        // other edge shifts it in, which moves miso on
        // on the eighth sample the byte completes at once and
        // a byte waiting in the holding buffer loads, so miso is ready for the next
        // select high clears the count, so a cut frame leaves
        // no partial bits behind
        if (!client || ss_high) begin
            st_nxt.cnt  = 3'h0;
            st_nxt.pend = 1'b0;
        end else if (samp) begin
            if (st_r.cnt == LAST_BIT) begin
                st_nxt.cnt     = 3'h0;
                st_nxt.pend    = 1'b0;
                st_nxt.rx      = byte_in;
                st_nxt.done_d1 = buffered;
                if (!buffered) begin
                    st_nxt.f_if      = 1'b1;
                    st_nxt.sh        = byte_in;
                    st_nxt.sh_loaded = 1'b0;
                end else if (st_r.txb_full) begin
                    st_nxt.sh        = st_r.txb;
                    st_nxt.sh_loaded = 1'b1;
                    st_nxt.txb_full  = 1'b0;
                    st_nxt.f_dre     = 1'b1;
                end else begin
                    st_nxt.sh        = byte_in;
                    st_nxt.sh_loaded = 1'b0;
                end
            end else begin
                st_nxt.cnt   = st_r.cnt + 3'h1;
                st_nxt.rxbit = st_r.mosi_sy[1];
                st_nxt.pend  = 1'b1;
            end
        end else if (shft && st_r.pend) begin
            st_nxt.sh   = shift_in(st_r.sh, st_r.rxbit, lsb);
            st_nxt.pend = 1'b0;
        end

        // done_d1 and done_d2 stage the buffered flags one and
        // two cycles behind the byte completion
        // extra flags only when buffered
        if (st_r.done_d1) begin
            st_nxt.f_rxc = 1'b1;
        end
        if (st_r.done_d2 && !st_r.txb_full && !st_r.sh_loaded) begin
            st_nxt.f_txc = 1'b1;
        end

        // serial output
        // miso shows the shifter end picked by the bit order;
        // the pad enable falls only while selected
        st_nxt.miso      = lsb ? st_r.sh[0] : st_r.sh[7];
        st_nxt.miso_oe_n = !(client && st_r.ctrl_b[CB_SO_OUT]
                             && !ss_high);
    end

    ////////////////////////////////////////////////////////////
    // state register
    // reset loads constants only; all flags low except the
    // empty flag; waitrequest and miso enable idle high
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_r           <= '0;
            st_r.ctrl_a    <= CTRL_A_RST;
            st_r.ctrl_b    <= CTRL_B_RST;
            st_r.f_dre     <= DRE_RST;
            st_r.waitreq   <= WAIT_RST;
            st_r.miso_oe_n <= OE_N_RST;
            // select synchroniser starts at the idle level
            st_r.ss_sy     <= SS_SY_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    // nothing between state and pins, so no glitches
    assign avl_readdata    = st_r.rdata;
    assign avl_waitrequest = st_r.waitreq;
    assign miso_out        = st_r.miso;
    assign miso_oe_n       = st_r.miso_oe_n;
endmodule // spi_client
`default_nettype wire

// *** spi_client_pkg.sv ***
// constants and carriers for the spi client block
// assumes a 200 MHz sys_clk and an avalon-mm master
package spi_client_pkg;
    // bus geometry
    localparam int ADDR_W = 5;
    // register word indexes, byte address = 4 * index
    localparam logic [2:0] IDX_CTRL_A = 3'h0;
    localparam logic [2:0] IDX_CTRL_B = 3'h1;
    localparam logic [2:0] IDX_FLAGS  = 3'h3;
    localparam logic [2:0] IDX_DATA   = 3'h4;
    // control_reg_a fields
    localparam int CA_ENABLE = 0;
    localparam int CA_HOST   = 5;
    localparam int CA_LSB    = 6;
    localparam logic [7:0] CA_MASK = 8'h61;
    // control_reg_b fields
    localparam int CB_CPHA    = 0;
    localparam int CB_CPOL    = 1;
    localparam int CB_SSD     = 2;
    localparam int CB_SS_OUT  = 3;
    localparam int CB_SO_OUT  = 4;
    localparam int CB_WFR     = 6;
    localparam int CB_BUF     = 7;
    localparam logic [7:0] CB_MASK = 8'hDF;
    // interrupt_flag_reg fields
    localparam int FL_IF    = 7;
    localparam int FL_WRITE_COLLISION_FLAG = 6;
    localparam int FL_RXC   = 7;
    localparam int FL_TXC   = 6;
    localparam int FL_DRE   = 5;
    // values after reset
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic       DRE_RST    = 1'b1;
    localparam logic       WAIT_RST   = 1'b1;
    localparam logic       OE_N_RST   = 1'b1;
    localparam logic [1:0] SS_SY_RST  = 2'h3;
    localparam logic [2:0] LAST_BIT   = 3'h7;
    // avalon request from the master
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [3:0]        byteenable;
        logic [31:0]       writedata;
    } avl_req_type;
    // serial pins seen by the client
    typedef struct packed {
        logic sck;
        logic ss_n;
        logic mosi;
    } spi_in_type;
endpackage

// *** spi_client_checker.sv ***
// port checker for the spi client block
// assumes binding onto spi_client, single sys_clk domain
`timescale 1ns/10ps
`default_nettype none
module spi_client_checker
    import spi_client_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rstn,
    // register bus
    input wire avl_req_type avl_req,
    input wire logic [31:0] avl_readdata,
    input wire logic        avl_waitrequest,
    // serial pins
    input wire spi_in_type  spi_in,
    input wire logic        miso_out,
    input wire logic        miso_oe_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic [3:0] quiet_r;  // cycles with no sck or select edge or write
    logic       sck_r;    // sck one cycle ago
    logic       ss_r;     // select one cycle ago
    ////////////////////////////////////////////////////////////
    // activity counter, restarts on any sck or select edge or bus write
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            quiet_r <= 4'h0;
            sck_r   <= 1'b0;
            ss_r    <= 1'b1;
        end else begin
            sck_r <= spi_in.sck;
            ss_r  <= spi_in.ss_n;
            if (spi_in.sck != sck_r || spi_in.ss_n != ss_r || avl_req.write)
                quiet_r <= 4'h0;
            else if (quiet_r != 4'hF)
                quiet_r <= quiet_r + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////
    // request taken, and a settled deselect
    sequence take_s;
        (avl_req.read || avl_req.write) && avl_waitrequest;
    endsequence
    sequence desel_s;
        spi_in.ss_n [*6];
    endsequence
    AST_ONE_WAIT: assert property (take_s |=> !avl_waitrequest)
        else $error("no answer one cycle after request");
    AST_WAIT_PULSE: assert property (!avl_waitrequest |=> avl_waitrequest)
        else $error("answer longer than one cycle");
    AST_IDLE_WAIT: assert property (!avl_req.read && !avl_req.write |=> avl_waitrequest)
        else $error("answer without request");
    AST_UPPER_ZERO: assert property (!avl_waitrequest |-> avl_readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_UNMAPPED: assert property (take_s ##0 (avl_req.read
        && avl_req.address[4:2] inside {3'h2, 3'h5, 3'h6, 3'h7}) |=> avl_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_RD_HOLD: assert property (!avl_req.read && !avl_req.write |=> $stable(avl_readdata))
        else $error("read data moved while idle");
    AST_MISO_TRI: assert property (desel_s |-> miso_oe_n)
        else $error("miso driven while deselected");
    AST_QUIET_HOLD: assert property (quiet_r >= 4'hA
        |-> $stable(miso_out) && $stable(miso_oe_n))
        else $error("miso moved without sck edge");
endmodule // spi_client_checker
bind spi_client spi_client_checker i_chk (
    .sys_clk(sys_clk), .rstn(rstn), .avl_req(avl_req), .avl_readdata(avl_readdata),
    .avl_waitrequest(avl_waitrequest), .spi_in(spi_in), .miso_out(miso_out),
    .miso_oe_n(miso_oe_n));
`default_nettype wire

// *** spi_host_model.sv ***
// behavioural remote spi host driving the client pins
// assumes a 64 ns sck period, clock still outside frames
`timescale 1ns/10ps
`default_nettype none
module spi_host_model
    import spi_client_pkg::*;
(
    // lines toward the client
    output var spi_in_type spi_out,
    // client data out and its enable
    input wire logic       miso_out,
    input wire logic       miso_oe_n
);
    // half period far above two clocks
    localparam int HALF = 32;
    logic last_v = 1'b0;  // last level driven on miso
    wire  miso_line;      // resolved miso wire
    initial spi_out = '{sck: 1'b0, ss_n: 1'b1, mosi: 1'b0};
    // undriven wire shows the inverse of its last level
    always @(miso_out or miso_oe_n) if (!miso_oe_n) last_v = miso_out;
    assign miso_line = miso_oe_n ? ~last_v : miso_out;
    ////////////////////////////////////////////////
    // select level; released mosi stops showing old bit
    task automatic sel(input logic lvl);
        spi_out.ss_n = lvl;
        if (lvl) spi_out.mosi = ~spi_out.mosi;
        #(2 * HALF);
    endtask
    // one frame of nbits, msb first
    task automatic xfer(input logic [1:0] mode, input logic [7:0] tx,
                        input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        // upper mode bit is idle level
        spi_out.sck = mode[1];
        sel(1'b0);
        // shift and sample on opposite edges
        for (int i = 0; i < nbits; i++) begin
            if (!mode[0]) spi_out.mosi = tx[7 - i];
            #HALF spi_out.sck = ~mode[1];
            if (mode[0]) spi_out.mosi = tx[7 - i];
            else rx = {rx[6:0], miso_line};
            #HALF spi_out.sck = mode[1];
            if (mode[0]) rx = {rx[6:0], miso_line};
        end
        #HALF;
        sel(1'b1);
    endtask
endmodule // spi_host_model
`default_nettype wire

// *** spi_client_test.sv ***
// self-checking bench for the spi client block
// assumes spi_host_model as far side, avalon tasks as software
`timescale 1ns/10ps
`default_nettype none
module spi_client_test
    import spi_client_pkg::*;
;
    localparam logic [7:0] RXD = (8'h01 << FL_RXC) | (8'h01 << FL_DRE);
    localparam logic [7:0] EN  = 8'h01 << CA_ENABLE;
    localparam logic [7:0] HST = 8'h01 << CA_HOST;
    localparam logic [7:0] SO  = 8'h01 << CB_SO_OUT;
    localparam logic [7:0] LSB = 8'h01 << CA_LSB;
    logic        sys_clk = 1'b0;     // 200 MHz clock
    logic        rstn    = 1'b0;     // async reset
    avl_req_type avl_req = '0;       // bus request
    logic [31:0] avl_readdata;       // bus read data
    logic        avl_waitrequest;    // bus stall
    spi_in_type  spi_in;             // pins from host model
    logic        miso_out;           // client data out
    logic        miso_oe_n;          // client out enable
    logic [7:0]  rx;                 // byte seen by host
    logic [3:0]  be_v = 4'hF;        // byte enables for bus
    logic [1:0]  lo_v = 2'h0;        // low address bits
    int          mismatches  = 0;    // failed compares
    int          checks_done = 0;    // all compares
    always #2.5 sys_clk = ~sys_clk;
    spi_client i_dut (.sys_clk(sys_clk), .rstn(rstn), .avl_req(avl_req),
        .avl_readdata(avl_readdata), .avl_waitrequest(avl_waitrequest),
        .spi_in(spi_in), .miso_out(miso_out), .miso_oe_n(miso_oe_n));
    spi_host_model i_host (.spi_out(spi_in), .miso_out(miso_out), .miso_oe_n(miso_oe_n));
    ////////////////////////////////////////////////
    // compares and verdict
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pin(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////
    // one avalon cycle, held until waitrequest low
    task automatic bus(input logic wr, input logic [2:0] idx, input logic [7:0] wd,
                       output logic [7:0] rdv);
        @(posedge sys_clk);
        avl_req <= '{read: !wr, write: wr, address: {idx, lo_v}, byteenable: be_v,
                     writedata: {24'h0, wd}};
        do begin
            @(posedge sys_clk);
        end while (avl_waitrequest !== 1'b0);
        rdv = avl_readdata[7:0];
        avl_req <= '0;
    endtask
    task automatic wr(input logic [2:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        bus(1'b1, idx, wd, d);
    endtask
    task automatic rdc(input logic [2:0] idx, input logic [7:0] e, input string nm);
        logic [7:0] d;
        bus(1'b0, idx, 8'h00, d);
        chk(nm, e, d);
    endtask
    // buffered frame: host byte, then flags and received byte
    task automatic bxfer(input logic [7:0] e, input logic [7:0] f);
        i_host.xfer(2'b00, ~e, 8, rx);
        chk("host rx", e, rx);
        rdc(IDX_FLAGS, f, "flags");
        rdc(IDX_DATA, ~e, "client rx");
        wr(IDX_FLAGS, 8'hC0);
    endtask
    // watchdog
    initial begin
        #100us;
        mismatches++;
        print_verdict;
    end
    ////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        rdc(IDX_CTRL_A, CTRL_A_RST, "ctrl_a");
        rdc(IDX_CTRL_B, CTRL_B_RST, "ctrl_b");
        be_v = 4'hE;
        wr(IDX_CTRL_B, 8'hFF);
        be_v = 4'hF;
        rdc(IDX_CTRL_B, CTRL_B_RST, "byte disabled");
        wr(3'h5, 8'hFF);
        rdc(3'h5, 8'h00, "unmapped");
        // select pin versus host mode
        wr(IDX_CTRL_B, 8'h01 << CB_SS_OUT);
        lo_v = 2'h3;
        rdc(IDX_CTRL_B, 8'h00, "misaligned");
        lo_v = 2'h0;
        wr(IDX_CTRL_A, EN | HST);
        i_host.sel(1'b0);
        rdc(IDX_CTRL_A, EN | HST, "host, select out");
        i_host.sel(1'b1);
        wr(IDX_CTRL_B, 8'h01 << CB_SSD);
        i_host.sel(1'b0);
        rdc(IDX_CTRL_A, EN | HST, "host, select ignored");
        i_host.sel(1'b1);
        wr(IDX_CTRL_B, 8'h00);
        i_host.sel(1'b0);
        rdc(IDX_CTRL_A, EN, "fallback");
        rdc(IDX_FLAGS, 8'h01 << FL_IF, "fallback flag");
        i_host.sel(1'b1);
        rdc(IDX_CTRL_A, EN, "stays client");
        wr(IDX_CTRL_A, EN | HST);
        rdc(IDX_CTRL_A, EN | HST, "host again");
        wr(IDX_CTRL_A, EN);
        // four modes, write during a frame refused
        for (int m = 0; m < 4; m++) begin
            wr(IDX_FLAGS, 8'hC0);
            wr(IDX_CTRL_B, SO | 8'(m));
            wr(IDX_DATA, 8'hA1 + 8'(m));
            fork
                i_host.xfer(2'(m), 8'h5C ^ 8'(m), 8, rx);
                begin
                    repeat (40) @(posedge sys_clk);
                    chk_pin("miso_oe_n", 1'b0, miso_oe_n);
                    wr(IDX_DATA, 8'h55);
                end
            join
            chk("host rx", 8'hA1 + 8'(m), rx);
            rdc(IDX_DATA, 8'h5C ^ 8'(m), "client rx");
            rdc(IDX_FLAGS, (8'h01 << FL_IF) | (8'h01 << FL_WRITE_COLLISION_FLAG), "flags");
        end
        chk_pin("miso_oe_n", 1'b1, miso_oe_n);
        // partial byte dropped on deselect
        wr(IDX_FLAGS, 8'hC0);
        i_host.xfer(2'b11, 8'hFF, 4, rx);
        rdc(IDX_FLAGS, 8'h00, "partial flags");
        wr(IDX_DATA, 8'h3C);
        i_host.xfer(2'b11, 8'h96, 8, rx);
        chk("host rx", 8'h3C, rx);
        rdc(IDX_DATA, 8'h96, "client rx");
        // lsb first in both directions
        wr(IDX_CTRL_A, EN | LSB);
        wr(IDX_DATA, 8'h0F);
        i_host.xfer(2'b11, 8'h69, 8, rx);
        chk("host rx lsb", 8'hF0, rx);
        rdc(IDX_DATA, 8'h96, "client rx lsb");
        wr(IDX_CTRL_A, EN);
        // buffered, wait-for-receive clear
        wr(IDX_CTRL_B, (8'h01 << CB_BUF) | SO);
        wr(IDX_FLAGS, 8'hC0);
        rdc(IDX_FLAGS, 8'h01 << FL_DRE, "empty idle");
        wr(IDX_DATA, 8'h43);
        rdc(IDX_FLAGS, 8'h00, "empty low");
        wr(IDX_DATA, 8'h45);
        bxfer(8'h96, RXD);
        bxfer(8'h43, RXD | (8'h01 << FL_TXC));
        // buffered, wait-for-receive set
        wr(IDX_CTRL_B, (8'h01 << CB_BUF) | (8'h01 << CB_WFR) | SO);
        wr(IDX_DATA, 8'h5A);
        rdc(IDX_FLAGS, 8'h01 << FL_DRE, "first write to shifter");
        wr(IDX_DATA, 8'h44);
        bxfer(8'h5A, RXD);
        bxfer(8'h44, RXD | (8'h01 << FL_TXC));
        print_verdict;
    end
endmodule // spi_client_test
`default_nettype wire
